// File: verilog/sfbs_pkg.sv
`default_nettype none
package sfbs_pkg;
    // flash command codes
    localparam logic [7:0] FLASH_STATUS_REGISTER_WRITE_CMD = 8'h01;
    localparam logic [7:0] FLASH_STATUS_REGISTER_READ_CMD  = 8'h05;
    localparam logic [7:0] FLASH_WRITE_ENABLE_CMD          = 8'h06;
    localparam logic [7:0] QUAD_READ_4B_CMD                = 8'hEC;
    // configuration register fields
    localparam int         QUAD_ENABLE_BIT_POS    = 1;
    localparam int         LATENCY_CODE_POS       = 6;
    localparam logic [1:0] LATENCY_CODE_RESET     = 2'h0;
    // status register busy flag position
    localparam int         BUSY_BIT_POS           = 0;
    // controller settings
    localparam logic [1:0] CHANNEL_ALLOWED        = 2'h0;
    localparam logic [2:0] CLK_DIV_RESET          = 3'h0;
    localparam logic [2:0] CLK_DIV_BY4            = 3'h4;
    localparam logic [2:0] CLK_DIV_BY2            = 3'h2;
    localparam logic [2:0] BUS_WIDTH_1            = 3'h1;
    localparam logic [2:0] BUS_WIDTH_4            = 3'h4;
    localparam logic [7:0] READ_CMD_RESET         = 8'h03;
    localparam logic [2:0] DELAY_RESET            = 3'h0;
    localparam int         POLL_LIMIT             = 1024;

    typedef enum logic [3:0] {
        SFBS_IDLE     = 4'h0,
        SFBS_STEP1    = 4'h1,
        SFBS_CACHE    = 4'h2,
        SFBS_WREN     = 4'h3,
        SFBS_WREN_W   = 4'h4,
        SFBS_WRREG    = 4'h5,
        SFBS_WRREG_W  = 4'h6,
        SFBS_POLL     = 4'h7,
        SFBS_POLL_W   = 4'h8,
        SFBS_WIDEN    = 4'h9,
        SFBS_READCMD  = 4'hA,
        SFBS_DONE     = 4'hB,
        SFBS_FAIL     = 4'hC
    } sfbs_state_t;
endpackage
`default_nettype wire

// File: verilog/sfbs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module sfbs_sequencer
    import sfbs_pkg::*;
#(
    parameter int          POLL_MAX = POLL_LIMIT,
    parameter logic [2:0]  DELAY_CYC = 3'h1,
    parameter logic [1:0]  LAT_CODE  = 2'h0
) (
    input  wire logic       clock,          // bus clock
    input  wire logic       rst,            // async reset, high
    input  wire logic       clk_en,         // freezes all state when low
    input  wire logic       start,          // one-cycle start request
    input  wire logic [1:0] channel,        // controller channel selected
    output logic            cmd_valid,      // command request to controller
    output logic [7:0]      cmd_code,       // command opcode
    output logic            cmd_has_data,   // command carries one data byte
    output logic [7:0]      cmd_wdata,      // data byte for register write
    input  wire logic       cmd_done,       // command finished pulse
    input  wire logic       cmd_err,        // command failed, with cmd_done
    input  wire logic [7:0] cmd_rdata,      // status byte read back
    output logic [2:0]      delay_cycles,   // inserted delay cycle count
    output logic [2:0]      clk_div,        // serial clock divisor
    output logic            cache_en,       // read cache enable
    output logic [2:0]      bus_width,      // transfer lines
    output logic [7:0]      read_cmd,       // memory-mapped read command
    output logic            busy,           // sequence running
    output logic            done,           // sequence finished ok
    output logic            fail            // sequence failed
);
    sfbs_state_t state_r;
    logic [7:0]  cmd_code_r;
    logic        has_data_r;
    logic [7:0]  wdata_r;
    logic        stage2_r;
    logic [10:0] poll_cnt_r;

    // config byte for the flash register write
    function automatic logic [7:0] cfg_byte(input logic [1:0] lc);
        logic [7:0] b;
        b = 8'h00;
        b[QUAD_ENABLE_BIT_POS] = 1'b1;
        b[LATENCY_CODE_POS +: 2] = lc;
        return b;
    endfunction

    // main sequence; first stage never touches flash, second writes config
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r    <= SFBS_IDLE;
            cmd_code_r <= 8'h00;
            has_data_r <= 1'b0;
            wdata_r    <= 8'h00;
            stage2_r   <= 1'b0;
            poll_cnt_r <= 11'h000;
        end else if (clk_en) begin
            case (state_r)
                SFBS_IDLE: begin
                    if (start) begin
                        // only channel 0 may carry the sequence
                        if (channel != CHANNEL_ALLOWED) begin
                            state_r <= SFBS_FAIL;
                        end else begin
                            state_r <= SFBS_STEP1;
                        end
                    end
                end
                SFBS_STEP1: begin
                    state_r <= SFBS_CACHE;
                end
                SFBS_CACHE: begin
                    state_r    <= SFBS_WREN;
                    cmd_code_r <= FLASH_WRITE_ENABLE_CMD;
                    has_data_r <= 1'b0;
                end
                SFBS_WREN: begin
                    state_r <= SFBS_WREN_W;
                end
                SFBS_WREN_W: begin
                    if (cmd_done) begin
                        if (cmd_err) begin
                            state_r <= SFBS_FAIL;
                        end else begin
                            state_r    <= SFBS_WRREG;
                            cmd_code_r <= FLASH_STATUS_REGISTER_WRITE_CMD;
                            has_data_r <= 1'b1;
                            wdata_r    <= cfg_byte(LAT_CODE);
                        end
                    end
                end
                SFBS_WRREG: begin
                    state_r <= SFBS_WRREG_W;
                end
                SFBS_WRREG_W: begin
                    if (cmd_done) begin
                        if (cmd_err) begin
                            state_r <= SFBS_FAIL;
                        end else begin
                            state_r    <= SFBS_POLL;
                            cmd_code_r <= FLASH_STATUS_REGISTER_READ_CMD;
                            has_data_r <= 1'b0;
                            poll_cnt_r <= 11'h000;
                        end
                    end
                end
                SFBS_POLL: begin
                    state_r <= SFBS_POLL_W;
                end
                SFBS_POLL_W: begin
                    if (cmd_done) begin
                        if (cmd_err) begin
                            state_r <= SFBS_FAIL;
                        end else if (cmd_rdata[BUSY_BIT_POS]) begin
                            // a dead flash must not hang boot forever
                            if (poll_cnt_r == 11'(POLL_MAX - 1)) begin
                                state_r <= SFBS_FAIL;
                            end else begin
                                poll_cnt_r <= poll_cnt_r + 11'h001;
                                state_r    <= SFBS_POLL;
                            end
                        end else begin
                            state_r <= SFBS_WIDEN;
                        end
                    end
                end
                SFBS_WIDEN: begin
                    state_r <= SFBS_READCMD;
                end
                SFBS_READCMD: begin
                    state_r  <= SFBS_DONE;
                    stage2_r <= 1'b1;
                end
                SFBS_DONE: begin
                    if (start) begin
                        state_r <= SFBS_IDLE;
                    end
                end
                SFBS_FAIL: begin
                    if (start) begin
                        state_r <= SFBS_IDLE;
                    end
                end
                default: begin
                    state_r <= SFBS_IDLE;
                end
            endcase
        end
    end

    // controller settings, moved in set states (STEP1, CACHE, WIDEN, READCMD) so order is kept
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            delay_cycles <= DELAY_RESET;
            clk_div      <= CLK_DIV_RESET;
            cache_en     <= 1'b0;
            bus_width    <= BUS_WIDTH_1;
            read_cmd     <= READ_CMD_RESET;
        end else if (clk_en) begin
            if (state_r == SFBS_STEP1) begin
                delay_cycles <= DELAY_CYC;
                clk_div      <= CLK_DIV_BY4;
            end
            if (state_r == SFBS_CACHE) begin
                cache_en <= 1'b1;
            end
            if (state_r == SFBS_WIDEN) begin
                bus_width <= BUS_WIDTH_4;
            end
            if (state_r == SFBS_READCMD) begin
                read_cmd <= QUAD_READ_4B_CMD;
                clk_div  <= CLK_DIV_BY2;
            end
        end
    end

    // command request is high for the one cycle of each issue state, not while waiting for done
    assign cmd_valid = (state_r == SFBS_WREN) || (state_r == SFBS_WRREG) ||
                       (state_r == SFBS_POLL);
    assign cmd_code     = cmd_code_r;
    assign cmd_has_data = has_data_r;
    assign cmd_wdata    = wdata_r;
    assign busy = (state_r != SFBS_IDLE) && (state_r != SFBS_DONE) &&
                  (state_r != SFBS_FAIL);
    assign done = (state_r == SFBS_DONE);
    assign fail = (state_r == SFBS_FAIL);

    // widening waits for a clean status poll
    a_widen_after_idle: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_r == SFBS_POLL_W && cmd_done && !cmd_err && cmd_rdata[BUSY_BIT_POS])
        |=> state_r != SFBS_WIDEN)
        else $error("bus widened while flash busy");
    a_idle_widens: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_r == SFBS_POLL_W && cmd_done && !cmd_err && !cmd_rdata[BUSY_BIT_POS])
        |=> state_r == SFBS_WIDEN)
        else $error("clean poll did not widen");
    a_div4_then_cache: assert property (@(posedge clock) disable iff (rst)
        $rose(cache_en) |-> clk_div == CLK_DIV_BY4 && delay_cycles == DELAY_CYC)
        else $error("cache enabled before clock set");
    a_wide_after_cfg: assert property (@(posedge clock) disable iff (rst)
        $rose(bus_width == BUS_WIDTH_4) |-> stage2_r == 1'b0 && read_cmd == READ_CMD_RESET)
        else $error("bus width changed out of order");
    a_readcmd_div2: assert property (@(posedge clock) disable iff (rst)
        $changed(read_cmd) |-> read_cmd == QUAD_READ_4B_CMD && clk_div == CLK_DIV_BY2 &&
        bus_width == BUS_WIDTH_4)
        else $error("read command set without div2");
    a_flash_status_register_write_cmd_code: assert property (@(posedge clock) disable iff (rst)
        (state_r == SFBS_WRREG) |-> cmd_valid && cmd_code == FLASH_STATUS_REGISTER_WRITE_CMD
        && cmd_wdata[QUAD_ENABLE_BIT_POS])
        else $error("register write has wrong code");
    a_poll_code: assert property (@(posedge clock) disable iff (rst)
        (state_r == SFBS_POLL) |-> cmd_code == FLASH_STATUS_REGISTER_READ_CMD && !cmd_has_data)
        else $error("poll has wrong code");
    a_err_fails: assert property (@(posedge clock) disable iff (rst)
        (clk_en && cmd_done && cmd_err && state_r == SFBS_WREN_W) |=> fail)
        else $error("command error not flagged");
    a_bad_channel: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_r == SFBS_IDLE && start && channel != CHANNEL_ALLOWED) |=> fail)
        else $error("bad channel accepted");
endmodule
`default_nettype wire

// File: bench/sfbs_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfbs_flash_model
    import sfbs_pkg::*;
(
    input  wire logic       clock,        // bus clock
    input  wire logic       rst,          // async reset, high
    input  wire logic       cmd_valid,    // command request
    input  wire logic [7:0] cmd_code,     // opcode
    input  wire logic       cmd_has_data, // data byte present
    input  wire logic [7:0] cmd_wdata,    // data byte
    input  wire logic [7:0] err_code,     // opcode answered with error
    input  wire logic [7:0] busy_polls,   // status reads that report busy
    input  wire logic [7:0] lat,          // answer latency in cycles, at least 1
    output logic            cmd_done,     // answer pulse
    output logic            cmd_err,      // answer error
    output logic [7:0]      cmd_rdata,    // status byte
    output logic [7:0]      last_wdata,   // last data byte seen
    output logic [7:0]      n_poll        // status reads seen
);
    logic [7:0] wait_r;
    logic [7:0] left_r;
    logic [7:0] code_r;
    // only register commands arrive here, never mapped reads: setup code runs off-path
    // one answer per command; status byte scrambles between answers so stale data fails
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_r <= 8'h00;
            left_r <= busy_polls;
            code_r <= 8'h00;
            n_poll <= 8'h00;
            cmd_done <= 1'b0;
            cmd_err <= 1'b0;
            cmd_rdata <= 8'hA5;
            last_wdata <= 8'h00;
        end else begin
            cmd_done <= 1'b0;
            cmd_err <= 1'b0;
            cmd_rdata <= ~cmd_rdata;
            if (cmd_valid) begin
                wait_r <= lat;
                code_r <= cmd_code;
                if (cmd_has_data) last_wdata <= cmd_wdata;
            end else if (wait_r == 8'h01) begin
                cmd_done <= 1'b1;
                cmd_err <= (code_r == err_code);
                if (code_r == FLASH_STATUS_REGISTER_READ_CMD) begin
                    cmd_rdata <= 8'h00;
                    cmd_rdata[BUSY_BIT_POS] <= (left_r != 8'h00);
                    n_poll <= n_poll + 8'h01;
                    if (left_r != 8'h00) left_r <= left_r - 8'h01;
                end
            end
            if (!cmd_valid && wait_r != 8'h00) wait_r <= wait_r - 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: bench/serial_flash_boot_setup_sequencer_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_flash_boot_setup_sequencer_test;
    import sfbs_pkg::*;
    localparam logic [2:0] DLY = 3'h3;
    localparam logic [1:0] LAT = 2'h2;
    logic       clock, rst, clk_en, start, cmd_valid, cmd_has_data, cmd_done, cmd_err;
    logic       cache_en, busy, done, fail, fin_d;
    logic [1:0] channel;
    logic [2:0] delay_cycles, clk_div, bus_width;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, read_cmd, last_wdata, err_code, polls, lat, n_poll;
    logic [8:0] exp_q[$];
    logic [8:0] e;
    logic [31:0] rng;
    int         err_count, num_checks;
    sfbs_sequencer #(.POLL_MAX(4), .DELAY_CYC(DLY), .LAT_CODE(LAT)) DUT (.clock(clock), .rst(rst),
        .clk_en(clk_en), .start(start), .channel(channel), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata),
        .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_rdata(cmd_rdata),
        .delay_cycles(delay_cycles), .clk_div(clk_div), .cache_en(cache_en),
        .bus_width(bus_width), .read_cmd(read_cmd), .busy(busy), .done(done), .fail(fail));
    sfbs_flash_model FLASH (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata), .err_code(err_code),
        .busy_polls(polls), .lat(lat), .cmd_done(cmd_done), .cmd_err(cmd_err),
        .cmd_rdata(cmd_rdata), .last_wdata(last_wdata), .n_poll(n_poll));
    // clock generator
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // result watcher: takes the oldest note when done or fail first shows
    always @(negedge clock) begin
        fin_d <= done | fail;
        if ((done | fail) && !fin_d && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk8({5'h00, busy, done, fail}, {5'h00, 1'b0, !e[8], e[8]});
            if (!e[8]) begin
                chk8(last_wdata, e[7:0]);
                chk8(n_poll, polls + 8'h01);
                chk8({5'h00, bus_width}, {5'h00, BUS_WIDTH_4});
                chk8(read_cmd, QUAD_READ_4B_CMD);
                chk8({5'h00, clk_div}, {5'h00, CLK_DIV_BY2});
                chk8({4'h0, cache_en, delay_cycles}, {4'h0, 1'b1, DLY});
            end
        end
    end
    // one boot sequence from reset, with a random answer latency
    task automatic run(input logic [1:0] ch, input logic [7:0] ec, input logic [7:0] np,
                       input logic ef);
        int k;
        rng = xs(rng);
        #1 rst = 1'b1;
        channel = ch;
        err_code = ec;
        polls = np;
        lat = 8'h01 + {6'h00, rng[1:0]};
        repeat (20) @(posedge clock);
        #1 rst = 1'b0;
        chk8({bus_width, clk_div, cache_en, busy}, {BUS_WIDTH_1, CLK_DIV_RESET, 2'h0});
        chk8(read_cmd, READ_CMD_RESET);
        exp_q.push_back({ef, (8'h01 << QUAD_ENABLE_BIT_POS) | (8'(LAT) << LATENCY_CODE_POS)});
        @(posedge clock);
        #1 start = 1'b1;
        @(posedge clock);
        #1 start = 1'b0;
        // freeze right after start: no setting may move while the enable is low
        clk_en = 1'b0;
        repeat (1 + rng[3:2]) @(posedge clock);
        #1 chk8({5'h00, clk_div}, {5'h00, CLK_DIV_RESET});
        clk_en = 1'b1;
        for (k = 0; k < 8 && ch == 2'h0 && clk_div !== CLK_DIV_BY4; k++) @(posedge clock) #1;
        if (ch == 2'h0) begin
            chk8({3'h0, busy, clk_div, cache_en}, {3'h0, 1'b1, CLK_DIV_BY4, 1'b0});
            @(posedge clock) #1;
            chk8({7'h00, cache_en}, 8'h01);
        end
        for (k = 0; k < 400 && !(done | fail); k++) @(posedge clock) #1;
        // a hang counts as a mismatch; the later runs are bounded as well
        if (k == 400) begin
            err_count++;
        end
        repeat (2) @(posedge clock);
    endtask
    initial begin
        rng = 32'hC57D;
        err_count = 0;
        num_checks = 0;
        clk_en = 1'b1;
        start = 1'b0;
        rst = 1'b1;
        channel = 2'h0;
        err_code = 8'hFF;
        polls = 8'h00;
        lat = 8'h01;
        run(2'h0, 8'hFF, 8'h00, 1'b0);
        run(2'h0, 8'hFF, 8'h03, 1'b0);
        run(2'h1, 8'hFF, 8'h00, 1'b1);
        run(2'h0, FLASH_WRITE_ENABLE_CMD, 8'h00, 1'b1);
        run(2'h0, FLASH_STATUS_REGISTER_WRITE_CMD, 8'h00, 1'b1);
        run(2'h0, FLASH_STATUS_REGISTER_READ_CMD, 8'h00, 1'b1);
        run(2'h0, 8'hFF, 8'h09, 1'b1);
        chk8(8'(exp_q.size()), 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
